// ---- core/edcm_ctrl_monitor.v ----
// operation control and address monitor of the ethernet dma engine
// assumes a same-clock engine datapath and an asynchronous nmi pin
//
// What this block does
// - fifo select 0 keeps running on fifo errors; 1 halts on them
// - set address error flag when a descriptor-supplied address is illegal
// - software writing 0 to address error flag clears it
// - nmi assertion halts the engine and sets the halted flag
// - software writing 0 to halted flag clears it and restarts the engine
// - fifo select, address error and halted flags reset to 0
// - expose current receive buffer write address, 32 bits
// - expose current receive descriptor fetch address, 32 bits
// - expose current transmit buffer read address, 32 bits
// - expose current transmit descriptor fetch address, 32 bits
// - monitor registers read-only, ignore writes, reset to 0
// - monitor values may lag the address actually in flight
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`include "edcm_regs.vh"

module edcm_ctrl_monitor #(
  parameter ADDR_W = 32
) (
  // clock and reset
  input  wire                    ref_clk,
  input  wire                    reset_n,
  // register port
  input  wire [`EDCM_ADDR_W-1:0] reg_addr,
  input  wire [31:0]             reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [31:0]             reg_rdata,
  // engine events
  input  wire                    nmi_pin,
  input  wire                    tx_fifo_underflow,
  input  wire                    rx_fifo_overflow,
  input  wire                    illegal_addr,
  // current addresses from the engine datapath
  input  wire                    rx_buf_valid,
  input  wire [ADDR_W-1:0]       rx_buffer_write_address,
  input  wire                    rx_desc_valid,
  input  wire [ADDR_W-1:0]       rx_descriptor_fetch_address,
  input  wire                    tx_buf_valid,
  input  wire [ADDR_W-1:0]       tx_buffer_read_address,
  input  wire                    tx_desc_valid,
  input  wire [ADDR_W-1:0]       tx_descriptor_fetch_address,
  // engine control
  output reg                     engine_halt,
  output reg                     address_error
);

  // ***************************************************************
  //  nmi synchroniser and edge
  // ***************************************************************
  reg nmi_meta_reg;
  reg nmi_sync_reg;
  reg nmi_prev_reg;
  wire nmi_rise;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_meta_reg <= `EDCM_ZERO1;
    end else begin
      nmi_meta_reg <= nmi_pin;
    end
  end

  // only the second stage feeds logic; the first may be metastable
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_sync_reg <= `EDCM_ZERO1;
    end else begin
      nmi_sync_reg <= nmi_meta_reg;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_prev_reg <= `EDCM_ZERO1;
    end else begin
      nmi_prev_reg <= nmi_sync_reg;
    end
  end

  // edge, so a held pin does not block the software restart
  assign nmi_rise = nmi_sync_reg & ~nmi_prev_reg;

  // ***************************************************************
  //  write decode
  // ***************************************************************
  wire wr_opctl;
  wire sel_wr_value;
  wire clr_addr_err;
  wire clr_halted;
  wire fifo_err;

  assign wr_opctl     = reg_wr & (reg_addr == `EDCM_OFS_OPCTL);
  assign sel_wr_value = reg_wdata[`EDCM_BIT_FIFO_SEL];
  // writing 1 to a flag bit leaves it as it is
  assign clr_addr_err = wr_opctl & ~reg_wdata[`EDCM_BIT_ADDR_ERR];
  assign clr_halted   = wr_opctl & ~reg_wdata[`EDCM_BIT_HALTED];
  assign fifo_err     = tx_fifo_underflow | rx_fifo_overflow;

  // ***************************************************************
  //  control register next state
  // ***************************************************************
  reg fifo_error_halt_select_reg;
  reg fifo_error_halt_select_next;
  reg address_error_flag_reg;
  reg address_error_flag_next;
  reg halted_flag_reg;
  reg halted_flag_next;
  reg fifo_halt_reg;
  reg fifo_halt_next;

  always @* begin
    fifo_error_halt_select_next = fifo_error_halt_select_reg;
    if (wr_opctl) begin
      fifo_error_halt_select_next = sel_wr_value;
    end
  end

  // set wins over a same-cycle clear
  always @* begin
    address_error_flag_next = address_error_flag_reg;
    if (illegal_addr) begin
      address_error_flag_next = `EDCM_ONE1;
    end else if (clr_addr_err) begin
      address_error_flag_next = `EDCM_ZERO1;
    end
  end

  // nmi edge wins over a same-cycle software clear
  always @* begin
    halted_flag_next = halted_flag_reg;
    if (nmi_rise) begin
      halted_flag_next = `EDCM_ONE1;
    end else if (clr_halted) begin
      halted_flag_next = `EDCM_ZERO1;
    end
  end

  // fifo halt has no flag of its own; released by select 0 or halted 0
  always @* begin
    fifo_halt_next = fifo_halt_reg;
    if (fifo_err && fifo_error_halt_select_reg) begin
      fifo_halt_next = `EDCM_ONE1;
    end else if (wr_opctl && !sel_wr_value) begin
      fifo_halt_next = `EDCM_ZERO1;
    end else if (clr_halted) begin
      fifo_halt_next = `EDCM_ZERO1;
    end
  end

  // ***************************************************************
  //  control register flops
  // ***************************************************************
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fifo_error_halt_select_reg <= `EDCM_ZERO1;
    end else begin
      fifo_error_halt_select_reg <= fifo_error_halt_select_next;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      address_error_flag_reg <= `EDCM_ZERO1;
    end else begin
      address_error_flag_reg <= address_error_flag_next;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      halted_flag_reg <= `EDCM_ZERO1;
    end else begin
      halted_flag_reg <= halted_flag_next;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fifo_halt_reg <= `EDCM_ZERO1;
    end else begin
      fifo_halt_reg <= fifo_halt_next;
    end
  end

  // ***************************************************************
  //  address monitor next state
  // ***************************************************************
  reg [31:0] rx_buf_mon_reg;
  reg [31:0] rx_buf_mon_next;
  reg [31:0] rx_desc_mon_reg;
  reg [31:0] rx_desc_mon_next;
  reg [31:0] tx_buf_mon_reg;
  reg [31:0] tx_buf_mon_next;
  reg [31:0] tx_desc_mon_reg;
  reg [31:0] tx_desc_mon_next;

  // captured in the valid cycle, readable one cycle later; good enough for progress watching
  always @* begin
    rx_buf_mon_next = rx_buf_mon_reg;
    if (rx_buf_valid) begin
      rx_buf_mon_next = rx_buffer_write_address[31:0];
    end
  end

  always @* begin
    rx_desc_mon_next = rx_desc_mon_reg;
    if (rx_desc_valid) begin
      rx_desc_mon_next = rx_descriptor_fetch_address[31:0];
    end
  end

  always @* begin
    tx_buf_mon_next = tx_buf_mon_reg;
    if (tx_buf_valid) begin
      tx_buf_mon_next = tx_buffer_read_address[31:0];
    end
  end

  always @* begin
    tx_desc_mon_next = tx_desc_mon_reg;
    if (tx_desc_valid) begin
      tx_desc_mon_next = tx_descriptor_fetch_address[31:0];
    end
  end

  // ***************************************************************
  //  address monitor flops
  // ***************************************************************
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_buf_mon_reg <= `EDCM_ADDR_RST;
    end else begin
      rx_buf_mon_reg <= rx_buf_mon_next;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_desc_mon_reg <= `EDCM_ADDR_RST;
    end else begin
      rx_desc_mon_reg <= rx_desc_mon_next;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_buf_mon_reg <= `EDCM_ADDR_RST;
    end else begin
      tx_buf_mon_reg <= tx_buf_mon_next;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_desc_mon_reg <= `EDCM_ADDR_RST;
    end else begin
      tx_desc_mon_reg <= tx_desc_mon_next;
    end
  end

  // ***************************************************************
  //  read mux
  // ***************************************************************
  reg [31:0] opctl_word;
  reg [31:0] rdata_next;

  // reserved bits stay 0 whatever software wrote
  always @* begin
    opctl_word                     = `EDCM_ZERO32;
    opctl_word[`EDCM_BIT_FIFO_SEL] = fifo_error_halt_select_reg;
    opctl_word[`EDCM_BIT_ADDR_ERR] = address_error_flag_reg;
    opctl_word[`EDCM_BIT_HALTED]   = halted_flag_reg;
  end

  // monitors have no write path at all
  always @* begin
    rdata_next = `EDCM_ZERO32;
    if (reg_rd) begin
      case (reg_addr)
        `EDCM_OFS_OPCTL: begin
          rdata_next = opctl_word;
        end
        `EDCM_OFS_RX_BUF: begin
          rdata_next = rx_buf_mon_reg;
        end
        `EDCM_OFS_RX_DESC: begin
          rdata_next = rx_desc_mon_reg;
        end
        `EDCM_OFS_TX_BUF: begin
          rdata_next = tx_buf_mon_reg;
        end
        `EDCM_OFS_TX_DESC: begin
          rdata_next = tx_desc_mon_reg;
        end
        default: begin
          rdata_next = `EDCM_ZERO32;
        end
      endcase
    end
  end

  // ***************************************************************
  //  read data flop
  // ***************************************************************
  // data held only for the cycle after the read strobe
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `EDCM_ZERO32;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  // ***************************************************************
  //  engine control outputs
  // ***************************************************************
  reg engine_halt_next;
  reg address_error_next;

  always @* begin
    engine_halt_next = halted_flag_reg | fifo_halt_reg;
  end

  always @* begin
    address_error_next = address_error_flag_reg;
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      engine_halt <= `EDCM_ZERO1;
    end else begin
      engine_halt <= engine_halt_next;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      address_error <= `EDCM_ZERO1;
    end else begin
      address_error <= address_error_next;
    end
  end

endmodule

// ---- core/edcm_regs.vh ----
// register offsets, field positions and reset values for the dma
// operation-control and address-monitor block
// assumes a word-indexed register port, 32-bit data
`ifndef EDCM_REGS_VH
`define EDCM_REGS_VH

`define EDCM_ADDR_W        4
`define EDCM_OFS_OPCTL     4'h0
`define EDCM_OFS_RX_BUF    4'h1
`define EDCM_OFS_RX_DESC   4'h2
`define EDCM_OFS_TX_BUF    4'h3
`define EDCM_OFS_TX_DESC   4'h4

`define EDCM_BIT_HALTED    0
`define EDCM_BIT_ADDR_ERR  1
`define EDCM_BIT_FIFO_SEL  2

`define EDCM_ZERO32        32'h0000_0000
`define EDCM_ZERO1         1'h0
`define EDCM_ONE1          1'h1
`define EDCM_ADDR_RST      32'h0000_0000

`endif

// ---- dv/edcm_chk.sv ----
// checker on the control/monitor ports
// assumes a bind onto edcm_ctrl_monitor
`timescale 1ns/1ps
`include "edcm_regs.vh"
module edcm_chk #(parameter ADDR_W = 32) (
  // clock, reset and register port
  input wire                    ref_clk,
  input wire                    reset_n,
  input wire                    reg_wr,
  input wire                    reg_rd,
  input wire [`EDCM_ADDR_W-1:0] reg_addr,
  input wire [31:0]             reg_wdata,
  input wire [31:0]             reg_rdata,
  // events, monitor and engine control
  input wire                    nmi_pin,
  input wire                    tx_fifo_underflow,
  input wire                    rx_fifo_overflow,
  input wire                    illegal_addr,
  input wire                    tx_buf_valid,
  input wire                    engine_halt,
  input wire                    address_error,
  input wire [ADDR_W-1:0]       tx_buffer_read_address
);
  // *****
  // select shadow: the bit itself is not at the ports
  // *****
  reg  sel_reg;
  wire ctl_wr = reg_wr && reg_addr == `EDCM_OFS_OPCTL;
  wire rd_ctl = reg_rd && reg_addr == `EDCM_OFS_OPCTL;
  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n) sel_reg <= 1'h0;
    else if (ctl_wr) sel_reg <= reg_wdata[2];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_fifo_halt: assert property (
    (tx_fifo_underflow || rx_fifo_overflow) && sel_reg |-> ##[1:3] engine_halt)
    else $error("fifo error did not halt");
  a_aerr_set: assert property (illegal_addr |-> ##2 address_error)
    else $error("address error not raised");
  a_aerr_read: assert property ($past(rd_ctl) |->
    reg_rdata[1] == address_error) else $error("address error read differs");
  a_aerr_clr: assert property (ctl_wr && !reg_wdata[1] && !illegal_addr
    |-> ##2 !address_error) else $error("address error not cleared");
  a_nmi_halt: assert property ($rose(nmi_pin) |-> ##[2:6] engine_halt)
    else $error("nmi did not halt");
  a_rst_quiet: assert property (!$past(reset_n) |->
    !engine_halt && !address_error) else $error("outputs set after reset");
  a_mon_read: assert property (tx_buf_valid ##1 !tx_buf_valid ##1
    (reg_rd && reg_addr == `EDCM_OFS_TX_BUF) |=>
    reg_rdata == $past(tx_buffer_read_address, 3))
    else $error("tx buffer monitor wrong");
  a_ctl_resv: assert property ($past(rd_ctl) |->
    reg_rdata[31:3] == 29'h0) else $error("reserved control bits set");
  c_illegal: cover property (illegal_addr);
  c_nmi: cover property ($rose(nmi_pin));
  c_fifo: cover property (tx_fifo_underflow && sel_reg);
endmodule

// ---- dv/edcm_mem.sv ----
// engine datapath and memory stand-in: posts one address per call
// assumes the bench calls post between other bus cycles
`timescale 1ns/1ps
module edcm_mem (
  // clock
  input wire        ref_clk,
  // strobes, address, illegal flag
  output reg [3:0]  vld,
  output reg [31:0] adr,
  output reg        bad
);
  initial begin
    vld = 4'h0;
    adr = 32'h0;
    bad = 1'h0;
  end
  // address inverted once stale, so a late capture cannot look right
  task post(input [1:0] k, input [31:0] a, input b);
    begin
      @(posedge ref_clk);
      vld <= 4'h1 << k;
      adr <= a;
      bad <= b;
      @(posedge ref_clk);
      vld <= 4'h0;
      adr <= ~a;
      bad <= 1'h0;
    end
  endtask
endmodule

// ---- dv/tb.sv ----
// self-checking bench for edcm_ctrl_monitor
// assumes edcm_mem drives the datapath side
`timescale 1ns/1ps
module tb;
  reg         ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, nmi_pin = 0;
  reg         tx_fifo_underflow = 0, rx_fifo_overflow = 0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [31:0] reg_wdata = 32'h0;
  wire [31:0] reg_rdata, adr;
  wire [3:0]  vld;
  wire        bad, engine_halt, address_error;
  integer     failures = 0, tests_run = 0, cyc = 0, k;
  always #12.5 ref_clk = ~ref_clk;
  edcm_mem i_edcm_mem (.ref_clk(ref_clk), .vld(vld), .adr(adr), .bad(bad));
  edcm_ctrl_monitor i_edcm_ctrl_monitor (.ref_clk(ref_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nmi_pin(nmi_pin), .tx_fifo_underflow(tx_fifo_underflow),
    .rx_fifo_overflow(rx_fifo_overflow), .illegal_addr(bad),
    .rx_buf_valid(vld[0]), .rx_buffer_write_address(adr),
    .rx_desc_valid(vld[1]), .rx_descriptor_fetch_address(adr),
    .tx_buf_valid(vld[2]), .tx_buffer_read_address(adr),
    .tx_desc_valid(vld[3]), .tx_descriptor_fetch_address(adr),
    .engine_halt(engine_halt), .address_error(address_error));
  // *****
  // tasks
  // *****
  task cmp(input [127:0] n, input [31:0] s, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("ERROR %0s exp %h got %h", n, e, s);
      end
    end
  endtask
  task conclude;
    begin
      if (failures == 0 && tests_run > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
      @(posedge ref_clk);
      reg_wr <= 1'h0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      @(posedge ref_clk);
      {reg_rd, reg_addr} <= {1'h1, a};
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 cmp("reg_rdata", reg_rdata, e);
    end
  endtask
  // one fifo error, u picks underflow or overflow
  task ev(input u, input [31:0] e);
    begin
      @(posedge ref_clk);
      {tx_fifo_underflow, rx_fifo_overflow} <= {u, !u};
      @(posedge ref_clk);
      {tx_fifo_underflow, rx_fifo_overflow} <= 2'h0;
      repeat (3) @(posedge ref_clk);
      #1 cmp("engine_halt", engine_halt, e);
    end
  endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      conclude;
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'h1;
    for (k = 0; k < 8; k = k + 1) rd(k[3:0], 32'h0);
    wr(4'h3, 32'hffff_ffff);
    rd(4'h3, 32'h0);
    wr(4'h0, 32'h4);
    rd(4'h0, 32'h4);
    ev(1'h1, 32'h1);
    wr(4'h0, 32'h0);
    ev(1'h0, 32'h0);
    for (k = 0; k < 4; k = k + 1) begin
      i_edcm_mem.post(k[1:0], 32'h1000_0010 << k, k == 2);
      rd(k[3:0] + 4'h1, 32'h1000_0010 << k);
    end
    rd(4'h0, 32'h2);
    cmp("address_error", address_error, 32'h1);
    wr(4'h0, 32'h0);
    rd(4'h0, 32'h0);
    cmp("address_error", address_error, 32'h0);
    @(posedge ref_clk) nmi_pin <= 1'h1;
    repeat (6) @(posedge ref_clk);
    #1 cmp("engine_halt", engine_halt, 32'h1);
    rd(4'h0, 32'h1);
    @(posedge ref_clk) nmi_pin <= 1'h0;
    wr(4'h0, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1 cmp("engine_halt", engine_halt, 32'h0);
    rd(4'h0, 32'h0);
    conclude;
  end
endmodule
bind edcm_ctrl_monitor edcm_chk #(.ADDR_W(ADDR_W)) i_edcm_chk (.*);
